// >>> piopt_pkg.sv
// Shared constants and types for the parallel I/O port transaction block.
package piopt_pkg;
	localparam int DATA_W = 16;
	// Strobe width field: one unit per code step, code 0 gives one unit.
	localparam int WIDTH_W = 2;
	// One unit is two input-clock periods; the block clock runs at half
	// the input clock, so one unit is one block clock cycle.
	localparam int CKI_PER_UNIT = 2;
	localparam int CKI_PER_CLK = 2;
	localparam int UNIT_CYCLES = (CKI_PER_UNIT + CKI_PER_CLK - 1) / CKI_PER_CLK;
	localparam int CNT_W = 4;
	// Settle count loaded at strobe release; an active input word is captured two cycles later.
	localparam logic [CNT_W-1:0] SETTLE_LAST = 4'h1;
	localparam int FIFO_DEPTH = 2;
	localparam int PTR_W = 1;
	localparam int LVL_W = 2;
	localparam logic [LVL_W-1:0] FIFO_FULL = 2'h2;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_STROBE,
		ST_HOLD,
		ST_SETTLE
	} piopt_phase_t;

	typedef struct packed {
		piopt_phase_t                     phase;
		logic [CNT_W-1:0]                 cnt;
		logic [CNT_W-1:0]                 width;
		logic                             wr;
		logic                             sel;
		logic [DATA_W-1:0]                out_word;
		logic                             ist1;
		logic                             ist2;
		logic                             ist3;
		logic                             ost1;
		logic                             ost2;
		logic                             ost3;
		logic [DATA_W-1:0]                db1;
		logic [DATA_W-1:0]                db2;
		logic [DATA_W-1:0]                db3;
		logic                             bus_oe;
		logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
		logic [PTR_W-1:0]                 wp;
		logic [PTR_W-1:0]                 rp;
		logic [LVL_W-1:0]                 level;
		logic                             overrun;
	} piopt_state_t;
endpackage

// >>> piopt_port.sv
// Parallel I/O port: active and passive strobe transactions with input buffer.
`timescale 1ns/1ns
module piopt_port #(
	parameter int DATA_W = piopt_pkg::DATA_W
) (
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic [1:0]        strobe_width_in,
	input  wire logic              out_strobe_drive_in,
	input  wire logic              in_strobe_drive_in,
	input  wire logic              cmd_valid_in,
	output logic                   cmd_ready_out,
	input  wire logic              cmd_write_in,
	input  wire logic              cmd_sel_in,
	input  wire logic [DATA_W-1:0] cmd_data_in,
	output logic                   rd_valid_out,
	input  wire logic              rd_ready_in,
	output logic [DATA_W-1:0]      rd_data_out,
	output logic                   overrun_out,
	output logic                   port_select_out,
	input  wire logic              input_strobe_n_in,
	output logic                   input_strobe_n_out,
	output logic                   input_strobe_n_oe_out,
	input  wire logic              output_strobe_n_in,
	output logic                   output_strobe_n_out,
	output logic                   output_strobe_n_oe_out,
	input  wire logic [DATA_W-1:0] parallel_data_bus_in,
	output logic [DATA_W-1:0]      parallel_data_bus_out,
	output logic                   parallel_data_bus_oe_out
);
	piopt_pkg::piopt_state_t s_q;
	piopt_pkg::piopt_state_t s_d;
	logic accept;
	logic push;
	logic pop;
	logic pass_in_edge;
	logic [DATA_W-1:0] push_data;
	logic [piopt_pkg::CNT_W-1:0] width_cyc;
	localparam int LVL_W = piopt_pkg::LVL_W;

	assign width_cyc = piopt_pkg::CNT_W'((32'(strobe_width_in) + 1)
		* piopt_pkg::UNIT_CYCLES);
	assign cmd_ready_out = (s_q.phase == piopt_pkg::ST_IDLE)
		&& (cmd_write_in || (in_strobe_drive_in
		&& s_q.level != piopt_pkg::FIFO_FULL));
	assign accept = cmd_valid_in && cmd_ready_out;
	assign pass_in_edge = !in_strobe_drive_in && s_q.ist2 && !s_q.ist3;
	assign rd_valid_out = s_q.level != '0;
	assign rd_data_out = s_q.mem[s_q.rp];
	assign pop = rd_valid_out && rd_ready_in;
	assign overrun_out = s_q.overrun;
	assign port_select_out = s_q.sel;
	assign input_strobe_n_oe_out = in_strobe_drive_in;
	assign output_strobe_n_oe_out = out_strobe_drive_in;
	assign input_strobe_n_out = !(s_q.phase == piopt_pkg::ST_STROBE
		&& !s_q.wr);
	assign output_strobe_n_out = !(s_q.phase == piopt_pkg::ST_STROBE
		&& s_q.wr);
	assign parallel_data_bus_out = s_q.out_word;
	assign parallel_data_bus_oe_out = s_q.bus_oe;

	always_comb begin
		s_d = s_q;
		push = 1'b0;
		push_data = s_q.db2;
		s_d.overrun = 1'b0;
		s_d.ist1 = input_strobe_n_in;
		s_d.ist2 = s_q.ist1;
		s_d.ist3 = s_q.ist2;
		s_d.ost1 = output_strobe_n_in;
		s_d.ost2 = s_q.ost1;
		s_d.ost3 = s_q.ost2;
		s_d.db1 = parallel_data_bus_in;
		s_d.db2 = s_q.db1;
		s_d.db3 = s_q.db2;
		unique case (s_q.phase)
			piopt_pkg::ST_IDLE: begin
				if (accept) begin
					s_d.phase = piopt_pkg::ST_STROBE;
					s_d.cnt = width_cyc - 1'b1;
					s_d.width = width_cyc;
					s_d.wr = cmd_write_in;
					s_d.sel = cmd_sel_in;
					if (cmd_write_in) begin
						s_d.out_word = cmd_data_in;
						if (!out_strobe_drive_in) begin
							s_d.phase = piopt_pkg::ST_IDLE;
						end
					end
				end
			end
			piopt_pkg::ST_STROBE: begin
				s_d.cnt = s_q.cnt - 1'b1;
				if (s_q.cnt == '0) begin
					s_d.phase = s_q.wr ? piopt_pkg::ST_HOLD
						: piopt_pkg::ST_SETTLE;
					s_d.cnt = piopt_pkg::SETTLE_LAST;
				end
			end
			piopt_pkg::ST_HOLD: begin
				s_d.phase = piopt_pkg::ST_IDLE;
			end
			piopt_pkg::ST_SETTLE: begin
				s_d.cnt = s_q.cnt - 1'b1;
				if (s_q.cnt == '0) begin
					s_d.phase = piopt_pkg::ST_IDLE;
					push = 1'b1;
				end
			end
		endcase
		// Passive capture uses the bus sample taken with the last low strobe.
		if (pass_in_edge) begin
			push_data = s_q.db3;
			if (s_q.level == piopt_pkg::FIFO_FULL && !pop) begin
				s_d.overrun = 1'b1;
			end else begin
				push = 1'b1;
			end
		end
		// Drive during an active write and one cycle after, or while a
		// host holds the output strobe low and one cycle after its release.
		// Only the second and third strobe flops are read, never the first.
		s_d.bus_oe = (s_d.phase == piopt_pkg::ST_STROBE && s_d.wr)
			|| s_d.phase == piopt_pkg::ST_HOLD
			|| (!out_strobe_drive_in
			&& (!s_q.ost2 || !s_q.ost3));
		if (push) begin
			s_d.mem[s_q.wp] = push_data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = s_q.rp + 1'b1;
		end
		s_d.level = s_q.level + LVL_W'(push) - LVL_W'(pop);
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			s_q <= '0;
			s_q.phase <= piopt_pkg::ST_IDLE;
			s_q.ist1 <= 1'b1;
			s_q.ist2 <= 1'b1;
			s_q.ist3 <= 1'b1;
			s_q.ost1 <= 1'b1;
			s_q.ost2 <= 1'b1;
			s_q.ost3 <= 1'b1;
			s_q.out_word <= piopt_pkg::DATA_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Helper: length of the current low stretch of the driven strobes.
	logic [piopt_pkg::CNT_W-1:0] low_len_q;
	always_ff @(posedge clock_in) begin
		if (rst_in || s_q.phase != piopt_pkg::ST_STROBE) begin
			low_len_q <= '0;
		end else begin
			low_len_q <= low_len_q + 1'b1;
		end
	end

	chk_read_strobe_start: assert property (@(posedge clock_in)
		disable iff (rst_in) accept && !cmd_write_in
		|=> !input_strobe_n_out && output_strobe_n_out)
		else $error("active read did not assert the input strobe");
	chk_select_follows_cmd: assert property (@(posedge clock_in)
		disable iff (rst_in) accept
		|=> port_select_out == $past(cmd_sel_in))
		else $error("port select does not match addressed register");
	chk_strobe_width_units: assert property (@(posedge clock_in)
		disable iff (rst_in)
		s_q.phase == piopt_pkg::ST_STROBE && s_q.cnt == '0
		|-> low_len_q + 1'b1 == s_q.width)
		else $error("strobe width differs from programmed units");
	chk_write_drives_data: assert property (@(posedge clock_in)
		disable iff (rst_in) accept && cmd_write_in && out_strobe_drive_in
		|=> !output_strobe_n_out && parallel_data_bus_oe_out
		&& parallel_data_bus_out == $past(cmd_data_in))
		else $error("active write did not drive strobe and data");
	chk_write_data_hold: assert property (@(posedge clock_in)
		disable iff (rst_in) out_strobe_drive_in && $rose(output_strobe_n_out)
		|-> parallel_data_bus_oe_out ##1 !parallel_data_bus_oe_out)
		else $error("active write data not held one cycle past strobe");
	chk_read_capture: assert property (@(posedge clock_in)
		disable iff (rst_in) $rose(input_strobe_n_out) && s_q.level == '0
		|-> ##2 rd_valid_out && rd_data_out == $past(s_q.db1, 2))
		else $error("active input word not captured at strobe release");
	chk_passive_drive: assert property (@(posedge clock_in)
		disable iff (rst_in) !out_strobe_drive_in && $fell(s_q.ost2)
		|=> parallel_data_bus_oe_out [*1] ##0 parallel_data_bus_out
		== s_q.out_word)
		else $error("passive output did not drive the bus");
	chk_passive_hold: assert property (@(posedge clock_in)
		disable iff (rst_in) !out_strobe_drive_in && $rose(s_q.ost2)
		&& $stable(out_strobe_drive_in)
		|=> parallel_data_bus_oe_out ##1 !parallel_data_bus_oe_out)
		else $error("passive output data not held after release");
	chk_bus_released: assert property (@(posedge clock_in)
		disable iff (rst_in) parallel_data_bus_oe_out
		|-> s_q.phase == piopt_pkg::ST_HOLD || !out_strobe_drive_in
		|| (s_q.phase == piopt_pkg::ST_STROBE && s_q.wr))
		else $error("bus driven outside an output transaction");

	cov_active_read: cover property (@(posedge clock_in)
		disable iff (rst_in) accept && !cmd_write_in && strobe_width_in == 2'h3);
	cov_active_write: cover property (@(posedge clock_in)
		disable iff (rst_in) accept && cmd_write_in && out_strobe_drive_in);
	cov_passive_in: cover property (@(posedge clock_in)
		disable iff (rst_in) pass_in_edge);
	cov_passive_out: cover property (@(posedge clock_in)
		disable iff (rst_in) !out_strobe_drive_in && $fell(s_q.ost2));
endmodule // piopt_port

// >>> piopt_peer.sv
// Far-side model: peripheral in active cycles, host in passive ones.
`timescale 1ns/1ns
module piopt_peer (
	input  wire logic        clk_in,
	input  wire logic        ids_dev_in,
	input  wire logic        ids_oe_in,
	input  wire logic        ods_dev_in,
	input  wire logic        ods_oe_in,
	input  wire logic        dev_oe_in,
	input  wire logic [15:0] dev_bus_in,
	input  wire logic        sel_in,
	input  wire logic [15:0] word_in,
	input  wire logic        pin_go_in,
	input  wire logic        pout_go_in,
	output logic             ids_n_out,
	output logic             ods_n_out,
	output logic [15:0]      bus_out
);
	logic [15:0] last_q = 16'h0000;
	assign ids_n_out = ids_oe_in ? ids_dev_in : !pin_go_in;
	assign ods_n_out = ods_oe_in ? ods_dev_in : !pout_go_in;
	// The source drives only while the input strobe is low; a released
	// bus shows the inverse of its last level.
	// In active reads the select picks one of two sources: register one
	// returns the word, register zero returns its inverse.
	always_comb begin
		if (dev_oe_in) begin
			bus_out = dev_bus_in;
		end else if (!ids_n_out) begin
			bus_out = (ids_oe_in && !sel_in) ? ~word_in : word_in;
		end else begin
			bus_out = ~last_q;
		end
	end
	always_ff @(posedge clk_in) begin
		last_q <= bus_out;
	end
endmodule // piopt_peer

// >>> test_parallel_io_port_transactions.sv
// Self-checking bench for the parallel port transaction block.
`timescale 1ns/1ns
module test_parallel_io_port_transactions;
	logic        clk = 0, rst = 1, ods_drv = 1, ids_drv = 1, cv = 0, cw = 0;
	logic        cs = 0, rdy = 1, pin_go = 0, pout_go = 0;
	logic [1:0]  wid = 2'h0;
	logic [15:0] cd = 16'h0000, word = 16'h0000, exp_q[$];
	logic [31:0] seed = 32'he9e544f3;
	logic        crdy, rv, ovr, sel, ids_o, ids_oe, ods_o, ods_oe, boe;
	logic        ids_n, ods_n;
	logic [15:0] rd, bus_o, bus;
	int          n_errors = 0, checks = 0, n_ovr = 0;
	always #2 clk = ~clk;
	piopt_port i_dut (.clock_in(clk), .rst_in(rst), .strobe_width_in(wid),
		.out_strobe_drive_in(ods_drv), .in_strobe_drive_in(ids_drv),
		.cmd_valid_in(cv), .cmd_ready_out(crdy), .cmd_write_in(cw),
		.cmd_sel_in(cs), .cmd_data_in(cd), .rd_valid_out(rv),
		.rd_ready_in(rdy), .rd_data_out(rd), .overrun_out(ovr),
		.port_select_out(sel), .input_strobe_n_in(ids_n),
		.input_strobe_n_out(ids_o), .input_strobe_n_oe_out(ids_oe),
		.output_strobe_n_in(ods_n), .output_strobe_n_out(ods_o),
		.output_strobe_n_oe_out(ods_oe), .parallel_data_bus_in(bus),
		.parallel_data_bus_out(bus_o), .parallel_data_bus_oe_out(boe));
	piopt_peer i_peer (.clk_in(clk), .ids_dev_in(ids_o), .ids_oe_in(ids_oe),
		.ods_dev_in(ods_o), .ods_oe_in(ods_oe), .dev_oe_in(boe),
		.dev_bus_in(bus_o), .sel_in(sel), .word_in(word),
		.pin_go_in(pin_go), .pout_go_in(pout_go), .ids_n_out(ids_n),
		.ods_n_out(ods_n), .bus_out(bus));
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string nm, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmd(input logic w, s, input logic [15:0] d);
		int i;
		@(posedge clk);
		cv <= 1;
		cw <= w;
		cs <= s;
		cd <= d;
		@(negedge clk);
		for (i = 0; i < 40 && crdy !== 1'b1; i++)
			@(negedge clk);
		if (i == 40) begin
			n_errors++;
			report_and_stop();
		end
		@(posedge clk);
		cv <= 0;
	endtask
	task automatic act(input logic w, input logic [1:0] code,
		input logic s, input logic [15:0] d);
		int i, n;
		bit held;
		n = 0;
		held = 0;
		@(posedge clk);
		wid <= code;
		word <= d;
		if (!w)
			exp_q.push_back(s ? d : ~d);
		cmd(w, s, d);
		for (i = 0; i < 12; i++) begin
			@(negedge clk);
			if ((w ? ods_o : ids_o) === 1'b0) begin
				n++;
				check("sel", 16'(sel), 16'(s));
				if (w) check("wdata", boe ? bus_o : 16'hx, d);
			end else if (n > 0 && !held) begin
				held = 1;
				if (w) check("hold", boe ? bus_o : 16'hx, d);
			end
		end
		check("width", 16'(n), 16'(code) + 16'h1);
		check("idle", 16'(boe), 16'h0);
	endtask
	task automatic pas_in(input logic [15:0] d);
		@(posedge clk);
		word <= d;
		pin_go <= 1;
		repeat (4) @(posedge clk);
		pin_go <= 0;
		repeat (6) @(posedge clk);
	endtask
	always @(negedge clk) begin
		if (ovr === 1'b1)
			n_ovr++;
		if (rv === 1'b1 && rdy)
			check("rdata", rd, exp_q.size() ? exp_q.pop_front() : 16'hx);
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		check("soe", 16'({ids_oe, ods_oe}), 16'h3);
		for (int k = 0; k < 8; k++) begin
			seed = step(seed);
			act(k[0], k[2:1], seed[8], seed[31:16]);
		end
		@(posedge clk);
		ids_drv <= 0;
		rdy <= 0;
		for (int k = 0; k < 3; k++) begin
			seed = step(seed);
			if (k < 2)
				exp_q.push_back(seed[15:0]);
			pas_in(seed[15:0]);
		end
		check("ovr", 16'(n_ovr), 16'h1);
		rdy <= 1;
		repeat (6) @(negedge clk);
		check("drain", 16'(exp_q.size()), 16'h0);
		@(posedge clk);
		ods_drv <= 0;
		seed = step(seed);
		cmd(1, 1'b1, seed[15:0]);
		@(negedge clk);
		check("soe2", 16'(ods_oe), 16'h0);
		@(posedge clk);
		pout_go <= 1;
		repeat (5) @(negedge clk);
		check("pout", boe ? bus_o : 16'hx, seed[15:0]);
		@(posedge clk);
		pout_go <= 0;
		@(negedge clk);
		check("phold", 16'(boe), 16'h1);
		repeat (3) @(negedge clk);
		check("phold2", boe ? bus_o : 16'hx, seed[15:0]);
		repeat (6) @(negedge clk);
		check("pfree", 16'(boe), 16'h0);
		report_and_stop();
	end
endmodule // test_parallel_io_port_transactions
